// [hw/rtf_formatter.sv]
// Seven-track tape record formatter with APB control and status registers.
// Functional notes
// - Seven tracks: six data, one parity.
// - Binary mode: data unchanged, odd parity.
// - BCD mode: translate code, even parity.
// - Gap written automatically after each record.
// - Read from first char to next gap.
// - Tape-mark record stops tape, sets end-of-file.
// - Tape-mark-only record is end-of-file, still forwarded.
// - Check character makes every track even.
// - Check character written short distance after data.
// - BCD check character even; binary may be odd.
// - Reverse binary scan may flag parity error.
// - One, two, three or four chars per word writable.
// - Gap sought after two characters read, or after one at one char per word.
// - One-char-per-word read stops on one noise char.
// - Reverse one-char scan stops after check character.
// - Not ready: no unit, not automatic, moving.
// - Character or longitudinal parity error sets error.
`include "rtf_defines.svh"
`default_nettype none
module rtf_formatter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rtf_pkg::rtf_chan_t ch_wr,
    output logic ch_wr_ready,
    output rtf_pkg::rtf_chan_t ch_rd,
    output rtf_pkg::rtf_char_t head_wr_char,
    output logic head_wr_stb,
    output logic head_erase,
    input wire rtf_pkg::rtf_char_t head_rd_char,
    input wire logic head_rd_stb,
    input wire logic head_gap,
    input wire logic unit_present,
    input wire logic unit_auto,
    output logic tape_motion,
    output logic tape_reverse,
    output logic tape_not_ready,
    output logic eof_flag,
    output logic err_flag
);
    localparam logic [7:0] LCC_CYC = 8'(`RTF_LCC_CYC);
    localparam logic [7:0] GAP_CYC = 8'(`RTF_GAP_CYC);

    rtf_pkg::rtf_state_t state;
    logic [31:0] ctrl;
    logic [15:0] char_cnt;
    logic [7:0] tmr;
    logic all_tm;
    logic par_pend;
    logic ctrl_wr;
    logic go_cmd;
    logic lrc_clear;
    logic lrc_upd;
    logic wr_take;
    logic rd_take;
    logic gap_ok;
    logic stop_ok;
    logic rec_end;
    logic rev_one_stop;
    logic lcc_due;
    logic gap_done;
    logic par_bad;
    logic [1:0] op;
    logic bcd;
    logic rev;
    logic [1:0] cpw_m1;
    logic [5:0] ch_dec;
    rtf_pkg::rtf_char_t wr_enc;
    rtf_pkg::rtf_char_t lrc_in;
    rtf_pkg::rtf_char_t lrc_acc;

    function automatic logic apb_hit(input logic [11:0] a, input logic [11:0] ofs);
        apb_hit = (a == ofs);
    endfunction : apb_hit

    assign op = ctrl[`RTF_CTRL_OP_HI:`RTF_CTRL_OP_LO];
    assign bcd = ctrl[`RTF_CTRL_BCD];
    assign rev = ctrl[`RTF_CTRL_REV];
    assign cpw_m1 = ctrl[`RTF_CTRL_CPW_HI:`RTF_CTRL_CPW_LO];
    // A control write while the tape moves is refused whole, so its go bit must not
    // clear the status of the command that is still running either.
    assign ctrl_wr = psel && penable && pready && pwrite && apb_hit(paddr, `RTF_CTRL_OFS)
                     && !tape_motion;
    assign go_cmd = ctrl_wr && pwdata[`RTF_CTRL_GO];
    assign wr_take = (state == rtf_pkg::st_wdata) && ch_wr.valid && ch_wr_ready;
    assign rd_take = head_rd_stb && ((state == rtf_pkg::st_rseek) || (state == rtf_pkg::st_rdata));

    rtf_xlate u_xlate (
        .bcd(bcd),
        .ch_data(ch_wr.data),
        .tape_in(head_rd_char),
        .tape_out(wr_enc),
        .ch_out(ch_dec),
        .par_bad(par_bad)
    );

    // The accumulator sees written characters, the emitted check character is left out,
    // and on read every sensed character including the check character is folded in.
    assign lrc_clear = go_cmd;
    assign lrc_upd = wr_take || rd_take;
    assign lrc_in = wr_take ? wr_enc : head_rd_char;

    rtf_lrc u_lrc (
        .pclk(pclk),
        .presetn(presetn),
        .clear(lrc_clear),
        .upd(lrc_upd),
        .ch(lrc_in),
        .acc(lrc_acc)
    );

    // Gap search opens after two characters, or after one when one char per word.
    assign gap_ok = (char_cnt >= 16'h0002) || ((cpw_m1 == 2'h0) && (char_cnt != 16'h0000));
    // A scan with fewer than three chars per word never ends on the gap.
    assign stop_ok = (op != `RTF_OP_SCAN) || (cpw_m1 >= 2'h2);
    assign rev_one_stop = (op == `RTF_OP_SCAN) && rev && (cpw_m1 == 2'h0)
                          && (state == rtf_pkg::st_rdata) && (char_cnt != 16'h0000);
    assign rec_end = (state == rtf_pkg::st_rdata) && ((head_gap && gap_ok && stop_ok) || rev_one_stop);
    // The last pause cycle launches the check character; the last gap cycle ends the write.
    assign lcc_due = (state == rtf_pkg::st_wpause) && (tmr <= 8'h01);
    assign gap_done = (state == rtf_pkg::st_wgap) && (tmr <= 8'h01);

    // APB slave: one wait-free access phase, unmapped addresses answer with an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(apb_hit(paddr, `RTF_CTRL_OFS) || apb_hit(paddr, `RTF_STAT_OFS)
                       || apb_hit(paddr, `RTF_CNT_OFS));
            if (psel && !penable && !pwrite) begin
                if (apb_hit(paddr, `RTF_CTRL_OFS)) begin
                    prdata <= {25'h0, ctrl[6:1], 1'b0};
                end else if (apb_hit(paddr, `RTF_STAT_OFS)) begin
                    prdata <= {28'h0, tape_not_ready, err_flag, eof_flag, tape_motion};
                end else if (apb_hit(paddr, `RTF_CNT_OFS)) begin
                    prdata <= {16'h0, char_cnt};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Control register; commands are refused while the tape is moving.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `RTF_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= {25'h0, pwdata[6:1], 1'b0};
        end
    end

    // Main sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rtf_pkg::st_idle;
            tmr <= 8'h00;
        end else begin
            unique case (state)
                rtf_pkg::st_idle: begin
                    if (go_cmd && !tape_motion) begin
                        state <= (pwdata[`RTF_CTRL_OP_HI:`RTF_CTRL_OP_LO] == `RTF_OP_WRITE)
                                 ? rtf_pkg::st_wdata : rtf_pkg::st_rseek;
                    end
                end
                rtf_pkg::st_wdata: begin
                    if (wr_take && ch_wr.last) begin
                        state <= rtf_pkg::st_wpause;
                        tmr <= LCC_CYC;
                    end
                end
                rtf_pkg::st_wpause: begin
                    // The check character trails the data by a short blank stretch.
                    if (lcc_due) begin
                        state <= rtf_pkg::st_wgap;
                        tmr <= GAP_CYC;
                    end else begin
                        tmr <= tmr - 8'h01;
                    end
                end
                rtf_pkg::st_wgap: begin
                    if (gap_done) begin
                        state <= rtf_pkg::st_idle;
                    end else begin
                        tmr <= tmr - 8'h01;
                    end
                end
                rtf_pkg::st_rseek: begin
                    if (head_rd_stb) begin
                        state <= rtf_pkg::st_rdata;
                    end
                end
                rtf_pkg::st_rdata: begin
                    if (rec_end) begin
                        state <= rtf_pkg::st_idle;
                    end
                end
            endcase
        end
    end

    // Character count of the current record; write accepts one char per two cycles
    // so any chars-per-word packing upstream keeps up.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            char_cnt <= 16'h0000;
        end else if (go_cmd) begin
            char_cnt <= 16'h0000;
        end else if ((wr_take || rd_take) && (char_cnt != 16'hFFFF)) begin
            // Saturating instead of wrapping keeps a long record from looking empty.
            char_cnt <= char_cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_wr_ready <= 1'b0;
        end else begin
            // Dropping ready for a cycle after each take paces the channel to one char per two.
            ch_wr_ready <= (state == rtf_pkg::st_wdata) && !wr_take;
        end
    end

    // Head write path: data characters, then the check character after the pause.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            head_wr_char <= '0;
            head_wr_stb <= 1'b0;
            head_erase <= 1'b0;
        end else begin
            head_wr_stb <= 1'b0;
            head_erase <= (state == rtf_pkg::st_wgap);
            if (wr_take) begin
                head_wr_char <= wr_enc;
                head_wr_stb <= 1'b1;
            end else if (lcc_due) begin
                // Track totals become even; in BCD every char is even so this one is too.
                head_wr_char <= lrc_acc;
                head_wr_stb <= 1'b1;
            end
        end
    end

    // Read path: every sensed character goes to the channel, tape marks included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_rd <= '0;
        end else begin
            ch_rd.valid <= rd_take && (op != `RTF_OP_WRITE);
            ch_rd.last <= 1'b0;
            if (rd_take) begin
                ch_rd.data <= ch_dec;
            end
        end
    end

    // Tape-mark tracking for end-of-file detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            all_tm <= 1'b0;
        end else if (go_cmd) begin
            all_tm <= 1'b1;
        end else if (rd_take && (head_rd_char != `RTF_TAPE_MARK)) begin
            all_tm <= 1'b0;
        end
    end

    // Forward, a character's parity is judged only once another follows it, so the
    // trailing check character escapes; reversed, it comes first and may be flagged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_pend <= 1'b0;
        end else if (go_cmd) begin
            par_pend <= 1'b0;
        end else if (rd_take) begin
            par_pend <= par_bad && !rev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_flag <= 1'b0;
        end else if (rd_take && (rev ? par_bad : par_pend)) begin
            err_flag <= 1'b1;
        end else if (rec_end && (lrc_acc != '0) && !rev_one_stop) begin
            err_flag <= 1'b1;
        end else if (go_cmd) begin
            err_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eof_flag <= 1'b0;
        end else if (rec_end && all_tm && (char_cnt != 16'h0000)) begin
            // Setting beats a go in the same cycle, so an end of file is never lost.
            eof_flag <= 1'b1;
        end else if (go_cmd) begin
            eof_flag <= 1'b0;
        end
    end

    // Motion runs from the command until the record ends or the write gap is done.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tape_motion <= 1'b0;
            tape_reverse <= 1'b0;
        end else if (go_cmd && !tape_motion) begin
            tape_motion <= 1'b1;
            tape_reverse <= pwdata[`RTF_CTRL_REV];
        end else if (rec_end || gap_done) begin
            tape_motion <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tape_not_ready <= 1'b1;
        end else begin
            // One cycle behind its inputs; software polls it, so the lag is harmless.
            tape_not_ready <= !unit_present || !unit_auto || tape_motion;
        end
    end
endmodule : rtf_formatter
`default_nettype wire

// [hw/rtf_defines.svh]
// Register offsets, field positions, reset values and timing counts of the tape record formatter.
`ifndef RTF_DEFINES_SVH
`define RTF_DEFINES_SVH
`define RTF_CTRL_OFS 12'h000
`define RTF_STAT_OFS 12'h004
`define RTF_CNT_OFS 12'h008
`define RTF_CTRL_GO 0
`define RTF_CTRL_OP_LO 1
`define RTF_CTRL_OP_HI 2
`define RTF_CTRL_BCD 3
`define RTF_CTRL_REV 4
`define RTF_CTRL_CPW_LO 5
`define RTF_CTRL_CPW_HI 6
`define RTF_OP_READ 2'h0
`define RTF_OP_WRITE 2'h1
`define RTF_OP_SCAN 2'h2
`define RTF_CTRL_RESET 32'h0000_0060
`define RTF_TAPE_MARK 7'h0F
`define RTF_BCD_ZERO 6'h0A
`define RTF_CLK_MHZ 250
`define RTF_LCC_SPACE_NS 16
`define RTF_GAP_NS 400
`define RTF_LCC_CYC ((`RTF_LCC_SPACE_NS * `RTF_CLK_MHZ + 999) / 1000)
`define RTF_GAP_CYC ((`RTF_GAP_NS * `RTF_CLK_MHZ + 999) / 1000)
`endif

// [hw/rtf_pkg.sv]
// Types shared by the tape record formatter files.
`default_nettype none
package rtf_pkg;
    typedef struct packed {
        logic par;
        logic [5:0] data;
    } rtf_char_t;
    typedef struct packed {
        logic valid;
        logic last;
        logic [5:0] data;
    } rtf_chan_t;
    typedef enum logic [2:0] {st_idle, st_wdata, st_wpause, st_wgap, st_rseek, st_rdata} rtf_state_t;
endpackage : rtf_pkg
`default_nettype wire

// [hw/rtf_xlate.sv]
// Channel to tape character coding: interchange translation and character parity.
`include "rtf_defines.svh"
`default_nettype none
module rtf_xlate (
    input wire logic bcd,
    input wire logic [5:0] ch_data,
    input wire rtf_pkg::rtf_char_t tape_in,
    output rtf_pkg::rtf_char_t tape_out,
    output logic [5:0] ch_out,
    output logic par_bad
);
    // Only the zero code and RTF_BCD_ZERO trade places in this table; the full interchange map lives outside.
    function automatic logic [5:0] rtf_swap(input logic [5:0] c);
        if (c == 6'h00) begin
            rtf_swap = `RTF_BCD_ZERO;
        end else if (c == `RTF_BCD_ZERO) begin
            rtf_swap = 6'h00;
        end else begin
            rtf_swap = c;
        end
    endfunction : rtf_swap

    always_comb begin
        tape_out.data = bcd ? rtf_swap(ch_data) : ch_data;
        tape_out.par = bcd ? ^tape_out.data : ~^tape_out.data;
        ch_out = bcd ? rtf_swap(tape_in.data) : tape_in.data;
        par_bad = bcd ? ^tape_in : ~^tape_in;
    end
endmodule : rtf_xlate
`default_nettype wire

// [hw/rtf_lrc.sv]
// Per-track longitudinal odd-even accumulator across all seven tracks.
`default_nettype none
module rtf_lrc (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic upd,
    input wire rtf_pkg::rtf_char_t ch,
    output rtf_pkg::rtf_char_t acc
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
        end else if (clear) begin
            acc <= '0;
        end else if (upd) begin
            acc <= acc ^ ch;
        end
    end
endmodule : rtf_lrc
`default_nettype wire

// [tb/rtf_sva.sv]
// Port-level assertion checker of the tape record formatter.
`include "rtf_defines.svh"
`default_nettype none
module rtf_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire rtf_pkg::rtf_chan_t ch_wr,
    input wire logic ch_wr_ready,
    input wire rtf_pkg::rtf_chan_t ch_rd,
    input wire rtf_pkg::rtf_char_t head_wr_char,
    input wire logic head_wr_stb,
    input wire logic head_erase,
    input wire logic head_rd_stb,
    input wire logic unit_present,
    input wire logic unit_auto,
    input wire logic tape_motion,
    input wire logic tape_not_ready,
    input wire logic eof_flag
);
    logic up, bcd_m, wr_m, take, acc;
    assign take = ch_wr.valid && ch_wr_ready;
    assign acc = psel && penable && pready && pwrite && paddr == `RTF_CTRL_OFS && !tape_motion;
    // Mode is mirrored from accepted control writes, since the checker sees no internal state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up <= 1'b0;
            bcd_m <= 1'b0;
            wr_m <= 1'b0;
        end else begin
            up <= 1'b1;
            if (acc) begin
                bcd_m <= pwdata[`RTF_CTRL_BCD];
                wr_m <= pwdata[2:1] == `RTF_OP_WRITE;
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_char_parity: assert property ($past(take) && head_wr_stb |-> ^head_wr_char == !bcd_m)
        else $error("character parity wrong");
    chk_wr_answer: assert property (take |=> head_wr_stb && !ch_wr_ready)
        else $error("write char not sent");
    chk_lcc_space: assert property (take && ch_wr.last |=> head_wr_stb ##1 !head_wr_stb ##1 !head_wr_stb
        ##[1:4] head_wr_stb)
        else $error("check character spacing wrong");
    chk_gap_after: assert property (take && ch_wr.last |-> ##[5:16] head_erase)
        else $error("no gap after record");
    chk_erase_hold: assert property ($rose(head_erase) |-> head_erase [*8])
        else $error("gap too short");
    chk_not_ready: assert property (up |-> tape_not_ready == $past(!unit_present || !unit_auto || tape_motion))
        else $error("ready status wrong");
    chk_eof_hold: assert property (eof_flag && !(acc && pwdata[0]) |=> eof_flag)
        else $error("end of file lost");
    chk_eof_stop: assert property ($rose(eof_flag) |-> ##[0:4] !tape_motion)
        else $error("tape not stopped at end of file");
    chk_rd_fwd: assert property (head_rd_stb && tape_motion && !wr_m |=> ch_rd.valid)
        else $error("read char not forwarded");
endmodule : rtf_sva
bind rtf_formatter rtf_sva i_rtf_sva (.*);
`default_nettype wire

// [tb/rtf_tape_model.sv]
// Behavioural tape heads: keep the last written record and play it back on request.
`default_nettype none
module rtf_tape_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire rtf_pkg::rtf_char_t head_wr_char,
    input wire logic head_wr_stb,
    input wire logic tape_motion,
    input wire logic tape_reverse,
    input wire logic play,
    output rtf_pkg::rtf_char_t head_rd_char,
    output logic head_rd_stb,
    output logic head_gap
);
    timeunit 1ns;
    timeprecision 1ps;
    rtf_pkg::rtf_char_t mem[16];
    int wn, pi, tmr;
    logic wact, pact, mot_d;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wn <= 0;
            pact <= 1'b0;
            wact <= 1'b0;
            mot_d <= 1'b0;
            head_rd_stb <= 1'b0;
            head_gap <= 1'b1;
            head_rd_char <= '0;
        end else begin
            mot_d <= tape_motion;
            head_rd_stb <= 1'b0;
            // Between strobes the lines carry no character, so they toggle rather than hold.
            head_rd_char <= ~head_rd_char;
            if (!tape_motion) wact <= 1'b0;
            if (head_wr_stb) begin
                mem[wact ? wn : 0] <= head_wr_char;
                wn <= wact ? wn + 1 : 1;
                wact <= 1'b1;
            end
            if (tape_motion && !mot_d && play) begin
                pact <= 1'b1;
                pi <= 0;
                tmr <= 0;
                head_gap <= 1'b0;
            end else if (pact && !tape_motion) begin
                // The heads go quiet with the transport, even inside a record.
                pact <= 1'b0;
            end else if (pact) begin
                tmr <= tmr == 2 ? 0 : tmr + 1;
                if (tmr == 2 && pi == wn) begin
                    pact <= 1'b0;
                    head_gap <= 1'b1;
                end else if (tmr == 2) begin
                    head_rd_char <= mem[tape_reverse ? wn - 1 - pi : pi];
                    head_rd_stb <= 1'b1;
                    pi <= pi + 1;
                end
            end
        end
    end
endmodule : rtf_tape_model
`default_nettype wire

// [tb/rtf_formatter_tb_top.sv]
// Self-checking testbench of the tape record formatter.
`include "rtf_defines.svh"
`default_nettype none
module rtf_formatter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, play = 1'b0, er, erased;
    logic unit_present = 1'b1, unit_auto = 1'b1, pready, pslverr, ch_wr_ready, head_wr_stb, head_erase;
    logic head_rd_stb, head_gap, tape_motion, tape_reverse, tape_not_ready, eof_flag, err_flag;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    rtf_pkg::rtf_chan_t ch_wr = '0;
    rtf_pkg::rtf_chan_t ch_rd;
    rtf_pkg::rtf_char_t head_wr_char, head_rd_char, lcc;
    rtf_pkg::rtf_char_t wq[$];
    logic [5:0] rq[$];
    logic [5:0] dat[$];
    int n_errors, cmp_count, cyc;
    rtf_formatter i_rtf_formatter (.*);
    rtf_tape_model i_rtf_tape_model (.*);
    initial begin
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (head_wr_stb) wq.push_back(head_wr_char);
        if (ch_rd.valid) rq.push_back(ch_rd.data);
        if (head_erase) erased = 1'b1;
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    task results();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic rtf_pkg::rtf_char_t enc(input logic bcd, input logic [5:0] d);
        logic [5:0] c;
        c = (bcd && d == 6'h00) ? `RTF_BCD_ZERO : d;
        return {bcd ? ^c : ~^c, c};
    endfunction : enc
    task idle();
        repeat (3) @(posedge pclk);
        while (tape_motion !== 1'b0) @(posedge pclk);
        while (tape_not_ready !== 1'b0) @(posedge pclk);
    endtask : idle
    task wr_rec(input logic bcd, input logic [1:0] cm);
        wq = {};
        erased = 1'b0;
        play <= 1'b0;
        apb(1'b1, `RTF_CTRL_OFS, {25'h0, cm, 1'b0, bcd, `RTF_OP_WRITE, 1'b1});
        foreach (dat[i]) begin
            ch_wr <= {1'b1, i == dat.size() - 1, dat[i]};
            do @(posedge pclk); while (ch_wr_ready !== 1'b1);
        end
        ch_wr <= '0;
        idle();
        lcc = '0;
        foreach (dat[i]) begin
            check(wq[i], enc(bcd, dat[i]));
            lcc = lcc ^ enc(bcd, dat[i]);
        end
        check(wq[dat.size()], lcc);
        check(wq.size(), dat.size() + 1);
        check(erased, 1'b1);
    endtask : wr_rec
    task rd_rec(input logic bcd, input logic [1:0] cm, input logic [1:0] op);
        rq = {};
        play <= 1'b1;
        apb(1'b1, `RTF_CTRL_OFS, {25'h0, cm, 1'b0, bcd, op, 1'b1});
        @(posedge pclk);
        check(eof_flag, 1'b0);
        idle();
        foreach (dat[i]) check(rq[i], dat[i]);
    endtask : rd_rec
    task sc_regs();
        apb(1'b0, `RTF_CTRL_OFS, 32'h0);
        check(rd, `RTF_CTRL_RESET);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'h0);
        check(er, 1'b1);
        unit_auto <= 1'b0;
        repeat (3) @(posedge pclk);
        check(tape_not_ready, 1'b1);
        unit_auto <= 1'b1;
        unit_present <= 1'b0;
        repeat (3) @(posedge pclk);
        check(tape_not_ready, 1'b1);
        unit_present <= 1'b1;
        repeat (3) @(posedge pclk);
        check(tape_not_ready, 1'b0);
    endtask : sc_regs
    task sc_binary();
        dat = '{6'h00, 6'h15, 6'h3F, 6'h2A};
        wr_rec(1'b0, 2'h2);
        rd_rec(1'b0, 2'h2, `RTF_OP_READ);
        check(rq.size(), 5);
        rd_rec(1'b0, 2'h3, `RTF_OP_SCAN);
        apb(1'b0, `RTF_STAT_OFS, 32'h0);
        check(rd, 32'h0);
    endtask : sc_binary
    task sc_reverse();
        rq = {};
        play <= 1'b1;
        apb(1'b1, `RTF_CTRL_OFS, {25'h0, 2'h0, 1'b1, 1'b0, `RTF_OP_SCAN, 1'b1});
        @(posedge pclk);
        check(tape_reverse, 1'b1);
        idle();
        check(rq.size(), 1);
        check(rq[0], lcc[5:0]);
        check(err_flag, 1'b1);
    endtask : sc_reverse
    task sc_bcd();
        dat = '{6'h00, 6'h01};
        wr_rec(1'b1, 2'h1);
        check(^wq[2], 1'b0);
        rd_rec(1'b1, 2'h1, `RTF_OP_READ);
    endtask : sc_bcd
    task sc_mark();
        dat = '{6'h0F};
        wr_rec(1'b1, 2'h0);
        check(wq[0], `RTF_TAPE_MARK);
        rd_rec(1'b1, 2'h0, `RTF_OP_READ);
        check(eof_flag, 1'b1);
        apb(1'b0, `RTF_STAT_OFS, 32'h0);
        check(rd, 32'h2);
    endtask : sc_mark
    initial begin
        repeat (12) @(posedge pclk);
        check(tape_not_ready, 1'b1);
        presetn <= 1'b1;
        sc_regs();
        sc_binary();
        sc_reverse();
        sc_bcd();
        sc_mark();
        results();
    end
endmodule : rtf_formatter_tb_top
`default_nettype wire
